// ---- logic/acisp_i2c_slave.sv ----
`timescale 1ns/1ns

module acisp_i2c_slave #(
   parameter logic [31:0] WAKE_LOW_CYCLES = acisp_pkg::WAKE_LOW_CYC,
   parameter logic [31:0] WAKE_HIGH_CYCLES = acisp_pkg::WAKE_HIGH_CYC,
   parameter logic [31:0] WATCHDOG_CYCLES = acisp_pkg::WATCHDOG_CYC
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // configuration
   input wire logic [7:0] cfg_bus_addr_in,
   output logic thresh_sel_out,
   // command engine
   input wire logic exec_done_in,
   input wire logic [acisp_pkg::BUF_PTR_W-1:0] buf_rd_addr_in,
   output logic [acisp_pkg::BYTE_W-1:0] buf_rd_data_out,
   output logic [acisp_pkg::BUF_PTR_W-1:0] buf_len_out,
   output logic cmd_start_out,
   output logic busy_out,
   // power state
   output logic awake_out,
   output logic sleep_out,
   output logic idle_out
);

   // ----------------------------------------
   // types and state
   // ----------------------------------------
   typedef enum logic [1:0] {ST_ASLEEP, ST_WAKE_LOW, ST_WAKE_HIGH, ST_AWAKE} acisp_state_t;
   typedef enum logic [2:0] {PH_NONE, PH_ADDR, PH_WORD, PH_DATA, PH_SKIP} acisp_phase_t;
   typedef enum logic [1:0] {LP_NONE, LP_SLEEP, LP_IDLE} acisp_lp_t;

   acisp_line_if line ();

   acisp_state_t state_reg, state_next;
   acisp_phase_t phase_reg, phase_next;
   acisp_lp_t lp_pend_reg, lp_pend_next;
   logic [31:0] tmr_reg, tmr_next;
   logic [31:0] wdog_reg, wdog_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic ack_slot_reg, ack_slot_next;
   logic sda_oe_reg, sda_oe_next;
   logic [acisp_pkg::BUF_PTR_W-1:0] ptr_reg, ptr_next;
   logic [7:0] count_reg, count_next;
   logic complete_reg, complete_next;
   logic busy_reg, busy_next;
   logic cmd_start_reg, cmd_start_next;
   logic sleep_reg, sleep_next;
   logic idle_reg, idle_next;
   logic thresh_reg, thresh_next;
   logic wr_en;
   logic [7:0] eff_count;
   logic accept;

   // ----------------------------------------
   // line sampling and input buffer
   // ----------------------------------------
   acisp_line_sampler u_sampler (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   acisp_cmd_buffer u_buffer (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(wr_en),
      .wr_addr_in(ptr_reg),
      .wr_data_in(shift_reg),
      .rd_addr_in(buf_rd_addr_in),
      .rd_data_out(buf_rd_data_out)
   );

   // first byte written is the count itself
   assign eff_count = (ptr_reg == '0) ? shift_reg : count_reg;
   assign accept = (ptr_reg <= acisp_pkg::BUF_LAST) && (ptr_reg == '0 || {1'b0, ptr_reg} < count_reg)
                   && !busy_reg;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      lp_pend_next = lp_pend_reg;
      tmr_next = tmr_reg;
      wdog_next = wdog_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      ack_slot_next = ack_slot_reg;
      sda_oe_next = sda_oe_reg;
      ptr_next = ptr_reg;
      count_next = count_reg;
      complete_next = complete_reg;
      busy_next = busy_reg;
      cmd_start_next = 1'b0;
      sleep_next = 1'b0;
      idle_next = 1'b0;
      thresh_next = cfg_bus_addr_in[acisp_pkg::THRESH_SEL_BIT];
      wr_en = 1'b0;

      // engine finished: buffer is free for the next command
      if (busy_reg && exec_done_in) begin
         busy_next = 1'b0;
         ptr_next = '0;
         count_next = 8'h00;
         complete_next = 1'b0;
      end

      unique case (state_reg)
         ST_ASLEEP: begin
            // clock activity has no path into this state
            sda_oe_next = 1'b0;
            if (!line.sda) begin
               state_next = ST_WAKE_LOW;
               tmr_next = 32'h0000_0001;
            end
         end
         ST_WAKE_LOW: begin
            if (line.sda) begin
               // a zero byte on a slow bus also qualifies, on every device
               if (tmr_reg > WAKE_LOW_CYCLES) begin
                  state_next = ST_WAKE_HIGH;
                  tmr_next = 32'h0000_0000;
               end else begin
                  state_next = ST_ASLEEP;
               end
            end else if (tmr_reg <= WAKE_LOW_CYCLES) begin
               tmr_next = tmr_reg + 32'h0000_0001;
            end
         end
         ST_WAKE_HIGH: begin
            // clock enabled only once the delay has run out
            if (tmr_reg >= WAKE_HIGH_CYCLES) begin
               state_next = ST_AWAKE;
               phase_next = PH_NONE;
               lp_pend_next = LP_NONE;
               wdog_next = 32'h0000_0000;
               bit_cnt_next = 4'h0;
               ack_slot_next = 1'b0;
            end else begin
               tmr_next = tmr_reg + 32'h0000_0001;
            end
         end
         ST_AWAKE: begin
            // a long low on data here is ordinary traffic, never a wake
            wdog_next = wdog_reg + 32'h0000_0001;
            if (wdog_reg >= WATCHDOG_CYCLES) begin
               // stuck bus or forgotten device: drop pointer, count and completion; busy is kept
               state_next = ST_ASLEEP;
               sda_oe_next = 1'b0;
               ptr_next = '0;
               count_next = 8'h00;
               complete_next = 1'b0;
               sleep_next = 1'b1;
            end else if (line.stop) begin
               phase_next = PH_NONE;
               sda_oe_next = 1'b0;
               ack_slot_next = 1'b0;
               if (lp_pend_reg == LP_SLEEP) begin
                  state_next = ST_ASLEEP;
                  ptr_next = '0;
                  count_next = 8'h00;
                  complete_next = 1'b0;
                  sleep_next = 1'b1;
               end else if (lp_pend_reg == LP_IDLE) begin
                  // buffer and engine state are left untouched
                  state_next = ST_ASLEEP;
                  idle_next = 1'b1;
               end else if (complete_reg && !busy_reg) begin
                  busy_next = 1'b1;
                  cmd_start_next = 1'b1;
                  complete_next = 1'b0;
               end
               lp_pend_next = LP_NONE;
            end else if (line.start) begin
               // repeated start restarts framing at the address byte
               phase_next = PH_ADDR;
               bit_cnt_next = 4'h0;
               ack_slot_next = 1'b0;
               sda_oe_next = 1'b0;
            end else if (line.scl_rise && phase_reg != PH_NONE && phase_reg != PH_SKIP
                         && bit_cnt_reg < acisp_pkg::BITS_PER_BYTE) begin
               shift_next = {shift_reg[6:0], line.sda};
               bit_cnt_next = bit_cnt_reg + 4'h1;
            end else if (line.scl_fall && ack_slot_reg) begin
               // end of ninth clock: hand the line back
               sda_oe_next = 1'b0;
               ack_slot_next = 1'b0;
               bit_cnt_next = 4'h0;
            end else if (line.scl_fall && bit_cnt_reg == acisp_pkg::BITS_PER_BYTE) begin
               ack_slot_next = 1'b1;
               sda_oe_next = 1'b0;
               unique case (phase_reg)
                  PH_ADDR: begin
                     if (shift_reg[7:1] != cfg_bus_addr_in[7:1]) begin
                        phase_next = PH_SKIP;
                     end else if (busy_reg) begin
                        phase_next = PH_SKIP;
                     end else if (shift_reg[acisp_pkg::RW_BIT]) begin
                        // read data is served elsewhere; address is acknowledged, then the line floats
                        sda_oe_next = 1'b1;
                        phase_next = PH_SKIP;
                     end else begin
                        sda_oe_next = 1'b1;
                        phase_next = PH_WORD;
                     end
                  end
                  PH_WORD: begin
                     phase_next = PH_SKIP;
                     if (shift_reg == acisp_pkg::WA_RESET) begin
                        sda_oe_next = 1'b1;
                        ptr_next = '0;
                        count_next = 8'h00;
                        complete_next = 1'b0;
                     end else if (shift_reg == acisp_pkg::WA_SLEEP) begin
                        sda_oe_next = 1'b1;
                        lp_pend_next = LP_SLEEP;
                     end else if (shift_reg == acisp_pkg::WA_IDLE) begin
                        sda_oe_next = 1'b1;
                        lp_pend_next = LP_IDLE;
                     end else if (shift_reg == acisp_pkg::WA_COMMAND) begin
                        sda_oe_next = 1'b1;
                        phase_next = PH_DATA;
                     end
                  end
                  PH_DATA: begin
                     if (accept) begin
                        // appended after whatever earlier blocks left
                        wr_en = 1'b1;
                        sda_oe_next = 1'b1;
                        ptr_next = ptr_reg + 7'h01;
                        count_next = eff_count;
                        complete_next = ({1'b0, ptr_reg} + 8'h01) >= eff_count;
                     end
                  end
                  default: begin
                     phase_next = PH_SKIP;
                  end
               endcase
            end
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= ST_ASLEEP;
         phase_reg <= PH_NONE;
         lp_pend_reg <= LP_NONE;
         tmr_reg <= 32'h0000_0000;
         wdog_reg <= 32'h0000_0000;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ack_slot_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         ptr_reg <= '0;
         count_reg <= 8'h00;
         complete_reg <= 1'b0;
         busy_reg <= 1'b0;
         cmd_start_reg <= 1'b0;
         sleep_reg <= 1'b0;
         idle_reg <= 1'b0;
         thresh_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         lp_pend_reg <= lp_pend_next;
         tmr_reg <= tmr_next;
         wdog_reg <= wdog_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         ack_slot_reg <= ack_slot_next;
         sda_oe_reg <= sda_oe_next;
         ptr_reg <= ptr_next;
         count_reg <= count_next;
         complete_reg <= complete_next;
         busy_reg <= busy_next;
         cmd_start_reg <= cmd_start_next;
         sleep_reg <= sleep_next;
         idle_reg <= idle_next;
         thresh_reg <= thresh_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // open drain: the driven level is always low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_reg;
   assign thresh_sel_out = thresh_reg;
   assign buf_len_out = ptr_reg;
   assign cmd_start_out = cmd_start_reg;
   assign busy_out = busy_reg;
   assign awake_out = (state_reg == ST_AWAKE);
   assign sleep_out = sleep_reg;
   assign idle_out = idle_reg;

endmodule : acisp_i2c_slave

// ---- common/acisp_pkg.sv ----
package acisp_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_LOW_TIME_NS = 60000;
   localparam int WAKE_HIGH_DELAY_NS = 2500000;
   localparam int WATCHDOG_TIME_NS = 1300000000;
   // least time rounds up, delay until ready rounds down
   localparam logic [31:0] WAKE_LOW_CYC = 32'((WAKE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] WAKE_HIGH_CYC = 32'(WAKE_HIGH_DELAY_NS / CLK_PERIOD_NS);
   localparam logic [31:0] WATCHDOG_CYC = 32'(WATCHDOG_TIME_NS / CLK_PERIOD_NS);

   // ----------------------------------------
   // input buffer
   // ----------------------------------------
   localparam int BUF_DEPTH = 84;
   localparam int BUF_PTR_W = 7;
   localparam int BYTE_W = 8;
   localparam logic [BUF_PTR_W-1:0] BUF_LAST = 7'h53;

   // ----------------------------------------
   // address byte fields and word addresses
   // ----------------------------------------
   localparam int RW_BIT = 0;
   localparam int THRESH_SEL_BIT = 3;
   localparam logic [7:0] WA_RESET = 8'h00;
   localparam logic [7:0] WA_SLEEP = 8'h01;
   localparam logic [7:0] WA_IDLE = 8'h02;
   localparam logic [7:0] WA_COMMAND = 8'h03;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : acisp_pkg

// ---- common/acisp_line_if.sv ----
`timescale 1ns/1ns
interface acisp_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;

   modport sampler (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
   modport core (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface : acisp_line_if

// ---- logic/acisp_line_sampler.sv ----
`timescale 1ns/1ns
module acisp_line_sampler (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // events
   acisp_line_if.sampler line
);

   logic [1:0] scl_sync_reg, scl_sync_next;
   logic [1:0] sda_sync_reg, sda_sync_next;
   logic scl_prev_reg, scl_prev_next;
   logic sda_prev_reg, sda_prev_next;

   always_comb begin
      scl_sync_next = {scl_sync_reg[0], scl_in};
      sda_sync_next = {sda_sync_reg[0], sda_in};
      scl_prev_next = scl_sync_reg[1];
      sda_prev_next = sda_sync_reg[1];
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= scl_sync_next;
         sda_sync_reg <= sda_sync_next;
         scl_prev_reg <= scl_prev_next;
         sda_prev_reg <= sda_prev_next;
      end
   end

   // only the second stage and its delayed copy feed any logic
   assign line.scl = scl_sync_reg[1];
   assign line.sda = sda_sync_reg[1];
   assign line.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
   assign line.scl_fall = !scl_sync_reg[1] && scl_prev_reg;
   // sda moving while scl is high both before and after
   assign line.start = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
   assign line.stop = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];

endmodule : acisp_line_sampler

// ---- logic/acisp_cmd_buffer.sv ----
`timescale 1ns/1ns
module acisp_cmd_buffer (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // write port
   input wire logic wr_en_in,
   input wire logic [acisp_pkg::BUF_PTR_W-1:0] wr_addr_in,
   input wire logic [acisp_pkg::BYTE_W-1:0] wr_data_in,
   // read port
   input wire logic [acisp_pkg::BUF_PTR_W-1:0] rd_addr_in,
   output logic [acisp_pkg::BYTE_W-1:0] rd_data_out
);

   logic [acisp_pkg::BYTE_W-1:0] mem [acisp_pkg::BUF_DEPTH];
   logic [acisp_pkg::BYTE_W-1:0] rd_data_next;

   always_comb begin
      rd_data_next = 8'hff;
      if (rd_addr_in <= acisp_pkg::BUF_LAST) begin
         rd_data_next = mem[rd_addr_in];
      end
   end

   // array holds no reset; contents only count below the write pointer
   always_ff @(posedge core_clk_in) begin
      if (wr_en_in && wr_addr_in <= acisp_pkg::BUF_LAST) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else begin
         rd_data_out <= rd_data_next;
      end
   end

endmodule : acisp_cmd_buffer

// ---- test/acisp_host_model.sv ----
`timescale 1ns/1ns
module acisp_host_model (
   // bus pins
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // ----------------------------------------
   // idle bus: clock parked high, data released
   // ----------------------------------------
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // ----------------------------------------
   // bus cycles, 80 ns per bit: 50 low, 30 high
   // ----------------------------------------
   task bus_start();
      sda_low_out = 1'b1;
      #40 scl_out = 1'b0;
   endtask : bus_start

   task send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #10 sda_low_out = !b[i];
         #40 scl_out = 1'b1;
         #30 scl_out = 1'b0;
      end
      // released early so the device has time to pull low
      #10 sda_low_out = 1'b0;
      #40 scl_out = 1'b1;
      #15 ack = !sda_in;
      #15 scl_out = 1'b0;
   endtask : send_byte

   task bus_stop();
      #10 sda_low_out = 1'b1;
      #40 scl_out = 1'b1;
      #40 sda_low_out = 0;
      #40;
   endtask : bus_stop

   task hold_low(input int ns);
      sda_low_out = 1'b1;
      #(ns) sda_low_out = 1'b0;
   endtask : hold_low
endmodule : acisp_host_model

// ---- test/acisp_i2c_slave_sva.sv ----
`timescale 1ns/1ns
module acisp_i2c_slave_chk (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // watched ports
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [7:0] cfg_bus_addr_in,
   input wire logic thresh_sel_out,
   input wire logic exec_done_in,
   input wire logic [acisp_pkg::BUF_PTR_W-1:0] buf_len_out,
   input wire logic cmd_start_out,
   input wire logic busy_out,
   input wire logic awake_out,
   input wire logic sleep_out,
   input wire logic idle_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   thresh_copy_a: assert property ($past(rst_n_in) |-> thresh_sel_out == $past(cfg_bus_addr_in[3]))
      else $error("threshold select does not follow address bit 3");
   launch_busy_a: assert property (cmd_start_out |-> ##[0:1] busy_out)
      else $error("command start without busy");
   launch_pulse_a: assert property (cmd_start_out |=> !cmd_start_out)
      else $error("command start longer than one cycle");
   exec_clear_a: assert property (busy_out && exec_done_in |=> !busy_out && buf_len_out == 7'h00)
      else $error("execution end did not clear busy and buffer");
   sleep_drop_a: assert property (sleep_out |-> ##[0:2] !awake_out)
      else $error("still awake after sleep");
   idle_drop_a: assert property (idle_out |-> ##[0:2] !awake_out)
      else $error("still awake after idle");
   asleep_quiet_a: assert property (!awake_out |-> !sda_oe_out)
      else $error("data line pulled while not awake");
   ack_low_a: assert property ($rose(sda_oe_out) || $fell(sda_oe_out) |-> !scl_in)
      else $error("acknowledge changed while clock high");
   ack_hold_a: assert property (sda_oe_out && scl_in |=> sda_oe_out)
      else $error("acknowledge released during clock high");
   buf_max_a: assert property (buf_len_out <= 7'h54)
      else $error("buffer length past end");
   drain_only_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");

   cover property (cmd_start_out);
   cover property (sleep_out);
   cover property (idle_out);
   cover property ($rose(sda_oe_out));
endmodule : acisp_i2c_slave_chk

bind acisp_i2c_slave acisp_i2c_slave_chk chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .cfg_bus_addr_in(cfg_bus_addr_in), .thresh_sel_out(thresh_sel_out),
   .exec_done_in(exec_done_in), .buf_len_out(buf_len_out), .cmd_start_out(cmd_start_out), .busy_out(busy_out),
   .awake_out(awake_out), .sleep_out(sleep_out), .idle_out(idle_out));

// ---- test/tb_auth_chip_i2c_slave.sv ----
`timescale 1ns/1ns
module tb_auth_chip_i2c_slave;
   // shortened counts keep the run small
   // low count above the longest zero run of a byte at the model's bit rate,
   // so ordinary traffic to a sleeping device never wakes it
   localparam logic [31:0] WL = 32'h64;
   localparam logic [31:0] WH = 32'h32;
   localparam logic [31:0] WD = 32'h4e20;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic exec_done_in = 1'b0;
   logic [7:0] cfg = 8'hc8;
   logic [6:0] rd_addr = 7'h00;
   logic scl, sda_low, sda_oe, sda_out, thresh, start, busy, awake, slp, idl;
   logic [7:0] rd_data;
   logic [6:0] len;
   logic [15:0] ak;
   int errors = 0;
   int tests_run = 0;
   int nstart = 0;
   int nsleep = 0;
   int nidle = 0;
   int n;
   // address, word, expected acks {word, address}
   logic [17:0] rows [5] = '{{8'hc8, 8'h00, 2'b11}, {8'hc8, 8'h04, 2'b01}, {8'hc8, 8'hff, 2'b01},
      {8'hca, 8'h03, 2'b00}, {8'h48, 8'h03, 2'b00}};
   // pull-up: released wire reads high
   wire sda_w = (sda_low || (sda_oe && sda_out === 1'b0)) ? 1'b0 : 1'b1;

   acisp_host_model host (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_w));
   acisp_i2c_slave #(.WAKE_LOW_CYCLES(WL), .WAKE_HIGH_CYCLES(WH), .WATCHDOG_CYCLES(WD)) uut (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_out(sda_oe), .cfg_bus_addr_in(cfg), .thresh_sel_out(thresh), .exec_done_in(exec_done_in),
      .buf_rd_addr_in(rd_addr), .buf_rd_data_out(rd_data), .buf_len_out(len), .cmd_start_out(start),
      .busy_out(busy), .awake_out(awake), .sleep_out(slp), .idle_out(idl));

   initial forever #5 core_clk_in = ~core_clk_in;

   always @(posedge core_clk_in) begin
      if (start === 1'b1) nstart++;
      if (slp === 1'b1) nsleep++;
      if (idl === 1'b1) nidle++;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task test_done();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   task cyc(input int k);
      repeat (k) @(posedge core_clk_in);
      #1;
   endtask : cyc

   task xfer(input logic [7:0] b[$]);
      ak = '0;
      host.bus_start();
      foreach (b[i]) host.send_byte(b[i], ak[i]);
      host.bus_stop();
      cyc(5);
   endtask : xfer

   task wake();
      host.hold_low(1500);
      n = 0;
      while (awake !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk(n >= WH - 5 && n <= WH + 10, "wake delay");
      if (n == 200) test_done();
   endtask : wake

   task fin_exec();
      exec_done_in = 1'b1;
      cyc(1);
      exec_done_in = 1'b0;
      cyc(3);
   endtask : fin_exec

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      cyc(10);
      rst_n_in = 1'b1;
      cyc(3);
      chk(sda_oe === 1'b0 && busy === 1'b0 && awake === 1'b0 && len === 7'h00, "reset state");
      chk(thresh === cfg[3], "threshold select");
      xfer('{8'hc8, 8'h00});
      chk(ak[1:0] === 2'b00, "asleep device answered");
      host.hold_low(100);
      cyc(100);
      chk(awake === 1'b0, "short low woke device");
      wake();
      host.hold_low(1500);
      cyc(10);
      chk(awake === 1'b1, "wake while awake");
      for (int i = 0; i < 5; i++) begin
         xfer('{rows[i][17:10], rows[i][9:2]});
         chk(ak[1:0] === rows[i][1:0], "address or word acknowledge");
      end
      // command split over two blocks, one byte too many
      xfer('{8'hc8, 8'h03, 8'h04, 8'h11});
      chk(ak[3:0] === 4'hf && nstart == 0 && len === 7'h02, "partial command");
      xfer('{8'hc8, 8'h03, 8'h22, 8'h33, 8'h44});
      chk(ak[4:0] === 5'h0f, "byte past count");
      chk(nstart == 1 && busy === 1'b1 && len === 7'h04, "command launch");
      rd_addr = 7'h03;
      cyc(2);
      chk(rd_data === 8'h33, "buffer order");
      xfer('{8'hc8, 8'h03});
      chk(ak[0] === 1'b0, "write while busy");
      xfer('{8'hc9});
      chk(ak[0] === 1'b0, "read while busy");
      fin_exec();
      chk(busy === 1'b0 && len === 7'h00, "execution end");
      xfer('{8'hc9});
      chk(ak[0] === 1'b1, "read when ready");
      xfer('{8'hc8, 8'h03, 8'h05, 8'haa});
      xfer('{8'hc8, 8'h00});
      chk(len === 7'h00, "counter reset");
      xfer('{8'hc8, 8'h03, 8'h02, 8'hbb});
      chk(nstart == 2, "command after reset");
      fin_exec();
      xfer('{8'hc8, 8'h02});
      chk(nidle == 1 && awake === 1'b0, "idle entry");
      xfer('{8'hc8, 8'h03});
      chk(ak[0] === 1'b0, "idle device answered");
      wake();
      xfer('{8'hc8, 8'h01});
      chk(nsleep == 1 && awake === 1'b0, "sleep entry");
      wake();
      n = 0;
      while (nsleep < 2 && n < WD + 100) begin
         cyc(1);
         n++;
      end
      chk(awake === 1'b0 && n > WD - 100 && nsleep == 2, "watchdog");
      test_done();
   end
endmodule : tb_auth_chip_i2c_slave
